// ### core/rcpd_pkg.sv
// Purpose: constants and types of the ranging command parameter decoder
// Assumes: 250 MHz core clock, APB with 32-bit data
// Notes: register indices are word indices; byte address is index times 4
package rcpd_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register word indices
    localparam logic [5:0] IDX_DATA7 = 6'h08;
    localparam logic [5:0] IDX_DATA0 = 6'h0F;
    localparam logic [5:0] IDX_CMD = 6'h10;
    localparam logic [5:0] IDX_STATUS = 6'h11;
    localparam logic [5:0] IDX_IRQ_CLR = 6'h12;
    localparam logic [5:0] IDX_IRQ_EN = 6'h13;
    localparam logic [5:0] IDX_TAG = 6'h14;
    localparam logic [5:0] IDX_STATE = 6'h15;
    // commands
    localparam logic [7:0] CMD_NONE = 8'h00;
    localparam logic [7:0] CMD_MEAS = 8'h02;
    localparam logic [7:0] CMD_MEAS_CAL = 8'h03;
    localparam logic [7:0] CMD_RESET = 8'h00;
    // parameter byte numbers
    localparam logic [2:0] BYTE_CAL = 3'h7;
    localparam logic [2:0] BYTE_ALG = 3'h6;
    localparam logic [2:0] BYTE_PERIOD = 3'h2;
    // calibration mask bits
    localparam int CAL_FACTORY_BIT = 0;
    localparam int CAL_STATE_BIT = 1;
    localparam logic [7:0] CAL_BLOCK_ADDR = 8'h20;
    // algorithm select bits
    localparam int ALG_HALF_BIT = 2;
    localparam int ALG_ATONCE_BIT = 4;
    localparam int ALG_COMBINE_BIT = 5;
    localparam int ALG_AWAKE_BIT = 7;
    // status, enable and clear layout
    localparam int STS_W = 2;
    localparam int STS_DONE = 0;
    localparam int STS_ABORT = 1;
    localparam logic [STS_W-1:0] STS_RESET = 2'h0;
    // timing
    localparam int CLK_MHZ = 250;
    localparam int PERIOD_UNIT_MS = 1;
    localparam int RANGE_TIME_US = 1000;
    localparam int MS_CYC_DEF = PERIOD_UNIT_MS * CLK_MHZ * 1000;
    localparam int RANGE_CYC_DEF = RANGE_TIME_US * CLK_MHZ;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RANGE = 2'b01,
        ST_WAIT = 2'b11
    } rcpd_state_t;
endpackage

// ### core/rcpd_cfg_if.sv
// Purpose: parameter bytes in, decoded measurement options out
// Assumes: one clock domain, purely combinational decode
// Notes: src is the register side, dec is the decoder
`timescale 1ns/1ps
interface rcpd_cfg_if;
    logic [7:0] calMask;
    logic [7:0] algSel;
    logic useCal;
    logic factoryCal;
    logic algState;
    logic halfRate;
    logic atOnce;
    logic combine;
    logic stayAwake;
    modport src (output calMask, algSel, useCal,
        input factoryCal, algState, halfRate, atOnce, combine, stayAwake);
    modport dec (input calMask, algSel, useCal,
        output factoryCal, algState, halfRate, atOnce, combine, stayAwake);
endinterface

// ### core/rcpd_decode.sv
// Purpose: decode calibration mask and algorithm select bytes
// Assumes: bytes are stable registers of the top module
// Notes: reserved algorithm bits 3 and 6 are ignored
`timescale 1ns/1ps
module rcpd_decode
    import rcpd_pkg::*;
(
    // parameter bytes and decoded options
    rcpd_cfg_if.dec cfg
);
    // mask byte only counts for the calibrated command
    assign cfg.factoryCal = cfg.useCal & cfg.calMask[CAL_FACTORY_BIT];
    assign cfg.algState = cfg.useCal & cfg.calMask[CAL_STATE_BIT];
    assign cfg.halfRate = cfg.algSel[ALG_HALF_BIT];
    assign cfg.atOnce = cfg.algSel[ALG_ATONCE_BIT];
    assign cfg.combine = cfg.algSel[ALG_COMBINE_BIT];
    assign cfg.stayAwake = cfg.algSel[ALG_AWAKE_BIT];
endmodule // rcpd_decode

// ### core/rcpd_top.sv
// Purpose: APB register file and measurement sequencer of the ranging command
// Assumes: host writes parameter bytes before the command byte
// Notes: one clock; abort pin is synchronised with three flip-flops
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
module rcpd_top
    import rcpd_pkg::*;
#(
    parameter int MS_CYC = MS_CYC_DEF,
    parameter int RANGE_CYC = RANGE_CYC_DEF
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rcpd_pkg::ADDR_W-1:0] paddr,
    input wire logic [rcpd_pkg::DATA_W-1:0] pwdata,
    output logic [rcpd_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // abort pin from outside
    input wire logic abortPin,
    // measurement controls
    output logic capturing,
    output logic emitterHalfRate,
    output logic combinedCapture,
    output logic standbyReq,
    output logic factoryCalUsed,
    output logic algStateUsed,
    output logic [7:0] calBlockAddr,
    // interrupt
    output logic irq
);
    import rcpd_pkg::*;

    logic [7:0] cmdData [8];
    logic [7:0] command, tag, period;
    logic [STS_W-1:0] irqStatus, irqEnable;
    rcpd_state_t state;
    logic [31:0] rangeCnt, periodCnt, rangeTarget, periodTarget;
    logic atOnce, abortLate, awake, pinLevel, pinRise, addrOk, wrEn, clrWr;
    logic start, stop, rangeEnd, periodDone, setDone, setAbort, next_err;
    logic [2:0] pinSync;
    logic [5:0] idx;
    logic [DATA_W-1:0] next_prdata;

    rcpd_cfg_if cfg ();

    rcpd_decode u_decode (
        .cfg(cfg.dec)
    );

    assign cfg.calMask = cmdData[BYTE_CAL];
    assign cfg.algSel = cmdData[BYTE_ALG];
    assign cfg.useCal = (command == CMD_MEAS_CAL);

    // apb decode
    assign idx = paddr[7:2];
    assign addrOk = (paddr[1:0] == 2'h0) && (idx >= IDX_DATA7)
        && (idx <= IDX_STATE);
    assign wrEn = psel & penable & pready & pwrite & addrOk;
    assign clrWr = wrEn && (idx == IDX_IRQ_CLR);

    always_comb
    begin
        next_prdata = '0;
        next_err = ~addrOk;
        if (idx >= IDX_DATA7 && idx <= IDX_DATA0)
            next_prdata[7:0] = cmdData[3'(IDX_DATA0 - idx)];
        else if (idx == IDX_CMD)
            next_prdata[7:0] = command;
        else if (idx == IDX_STATUS)
            next_prdata[STS_W-1:0] = irqStatus;
        else if (idx == IDX_IRQ_EN)
            next_prdata[STS_W-1:0] = irqEnable;
        else if (idx == IDX_TAG)
            next_prdata[7:0] = tag;
        else if (idx == IDX_STATE)
            next_prdata[1:0] = state;
    end

    // zero wait: ready is raised by the setup cycle itself
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & next_err;
            prdata <= (psel & ~penable & ~pwrite) ? next_prdata : '0;
        end
    end

    // parameter bytes, byte n sits at index 0x0F minus n
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_data
            always_ff @(posedge core_clk)
            begin
                if (srst)
                    cmdData[gi] <= 8'h00;
                else if (wrEn && idx == 6'(IDX_DATA0 - gi))
                    cmdData[gi] <= pwdata[7:0];
            end
        end
    endgenerate

    // command is taken one cycle after the write and then reads 0x00
    always_ff @(posedge core_clk)
    begin
        if (srst)
            command <= CMD_NONE;
        else if (wrEn && idx == IDX_CMD)
            command <= pwdata[7:0];
        else
            command <= CMD_NONE;
    end

    assign start = (command == CMD_MEAS) || (command == CMD_MEAS_CAL);
    // explicit write of 0x00 ends a repeating series
    assign stop = wrEn && (idx == IDX_CMD) && (pwdata[7:0] == CMD_RESET);

    // abort pin: three flops, change counts when second and third agree
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pinSync <= 3'h0;
            pinLevel <= 1'b0;
        end
        else
        begin
            pinSync <= {pinSync[1:0], abortPin};
            if (pinSync[1] == pinSync[2])
                pinLevel <= pinSync[2];
        end
    end
    assign pinRise = (pinSync[1] == pinSync[2]) & pinSync[2] & ~pinLevel;

    assign rangeTarget = emitterHalfRate ? 32'(2 * RANGE_CYC)
        : 32'(RANGE_CYC);
    assign periodTarget = 32'(period) * 32'(MS_CYC);
    assign rangeEnd = (state == ST_RANGE) && (rangeCnt >= rangeTarget - 1);
    assign periodDone = periodCnt >= periodTarget - 1;
    assign setDone = rangeEnd;
    // at-once mode reports on the pin, otherwise at completion
    assign setAbort = (state == ST_RANGE) &&
        ((atOnce && pinRise) || (!atOnce && rangeEnd && abortLate));

    // sequencer
    always_ff @(posedge core_clk)
    begin
        if (srst)
            state <= ST_IDLE;
        else if (stop)
            state <= ST_IDLE;
        else
            unique case (state)
                ST_IDLE:
                    if (start)
                        state <= ST_RANGE;
                ST_RANGE:
                    if (start)
                        state <= ST_RANGE;
                    else if (rangeEnd)
                    begin
                        if (period == 8'h00)
                            state <= ST_IDLE;
                        else if (periodDone)
                            state <= ST_RANGE;
                        else
                            state <= ST_WAIT;
                    end
                ST_WAIT:
                    if (start || periodDone)
                        state <= ST_RANGE;
                default: state <= ST_IDLE;
            endcase
    end

    // counters run from the start of each measurement
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rangeCnt <= '0;
            periodCnt <= '0;
        end
        else if (start || (state != ST_RANGE && periodDone)
            || (rangeEnd && periodDone))
        begin
            rangeCnt <= '0;
            periodCnt <= '0;
        end
        else
        begin
            rangeCnt <= (state == ST_RANGE) ? rangeCnt + 32'h1 : '0;
            periodCnt <= periodCnt + 32'h1;
        end
    end

    // options are latched at the command so later byte writes wait
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            emitterHalfRate <= 1'b0;
            combinedCapture <= 1'b0;
            factoryCalUsed <= 1'b0;
            algStateUsed <= 1'b0;
            calBlockAddr <= 8'h00;
            atOnce <= 1'b0;
            period <= 8'h00;
        end
        else if (start)
        begin
            emitterHalfRate <= cfg.halfRate;
            combinedCapture <= cfg.combine;
            factoryCalUsed <= cfg.factoryCal;
            algStateUsed <= cfg.algState;
            calBlockAddr <= (cfg.factoryCal | cfg.algState)
                ? CAL_BLOCK_ADDR : 8'h00;
            atOnce <= cfg.atOnce;
            period <= cmdData[BYTE_PERIOD];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            abortLate <= 1'b0;
        else if (start || rangeEnd)
            abortLate <= 1'b0;
        else if (state == ST_RANGE && pinRise && !atOnce)
            abortLate <= 1'b1;
    end

    // standby between measurements unless the awake option is latched
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            awake <= 1'b0;
            capturing <= 1'b0;
            standbyReq <= 1'b0;
        end
        else
        begin
            if (start)
                awake <= cfg.stayAwake;
            capturing <= (state == ST_RANGE);
            standbyReq <= (state == ST_WAIT) && !awake;
        end
    end

    // sticky status: a set in the same cycle as a clear wins
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            irqStatus <= STS_RESET;
            irqEnable <= STS_RESET;
            tag <= 8'h00;
            irq <= 1'b0;
        end
        else
        begin
            irqStatus <= (irqStatus & ~(clrWr ? pwdata[STS_W-1:0]
                : STS_RESET)) | {setAbort, setDone};
            if (wrEn && idx == IDX_IRQ_EN)
                irqEnable <= pwdata[STS_W-1:0];
            if (setDone)
                tag <= tag + 8'h01;
            irq <= |(irqStatus & irqEnable);
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_rangeStart;
        start ##1 (state == ST_RANGE);
    endsequence

    a_cmd_clears: assert property (start |=> command == CMD_NONE)
        else $error("command not cleared after being taken");
    a_meas_start: assert property ((start && !stop) |-> s_rangeStart)
        else $error("measurement did not start");
    a_mask_ignored: assert property ((command == CMD_MEAS) |=>
        !factoryCalUsed && !algStateUsed)
        else $error("mask byte used by plain command");
    a_half_time: assert property ((state == ST_RANGE && emitterHalfRate
        && rangeCnt < 32'(2 * RANGE_CYC - 1)) |-> !rangeEnd)
        else $error("half rate did not double ranging time");
    a_abort_now: assert property ((state == ST_RANGE && atOnce && pinRise
        && !stop) |=> irqStatus[STS_ABORT])
        else $error("abort not reported at once");
    a_abort_defer: assert property ((!atOnce && !rangeEnd
        && !irqStatus[STS_ABORT]) |=> !irqStatus[STS_ABORT])
        else $error("abort reported before completion");
    a_done_tag: assert property (setDone |=> irqStatus[STS_DONE]
        && tag == $past(tag) + 8'h01)
        else $error("completion not flagged or tag not updated");
    a_irq_level: assert property ((irqStatus[STS_DONE] && irqEnable[STS_DONE])
        |=> irq)
        else $error("enabled completion did not raise interrupt");
    a_single_shot: assert property ((rangeEnd && period == 8'h00 && !start
        && !stop) |=> state == ST_IDLE)
        else $error("single measurement repeated");
    a_cal_block: assert property (factoryCalUsed |->
        calBlockAddr == CAL_BLOCK_ADDR)
        else $error("calibration block not selected");
endmodule // rcpd_top

// ### verification/rcpd_host.sv
// Purpose: host model, an APB master that loads parameter bytes and commands
// Assumes: one clock; the slave answers when it likes
// Notes: request signals change by non-blocking assignment after an edge
`timescale 1ns/1ps
module rcpd_host
    import rcpd_pkg::*;
(
    // clock
    input wire logic core_clk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [rcpd_pkg::ADDR_W-1:0] paddr,
    output logic [rcpd_pkg::DATA_W-1:0] pwdata,
    input wire logic [rcpd_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [31:0] rdata;
    logic rerr;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task xfer(input logic w, input logic [5:0] idx, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep looking valid
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask
    task load(input logic [7:0] mask, input logic [7:0] alg,
        input logic [7:0] period);
        xfer(1'b1, IDX_DATA7, {24'h0, mask | {7'h0, mask[1]}});
        xfer(1'b1, IDX_DATA7 + 6'h01, {24'h0, (alg | 8'h03) & 8'hB7});
        xfer(1'b1, IDX_DATA0 - 6'h03, {24'h0, 1'b0, alg[2], 6'h0});
        xfer(1'b1, IDX_DATA0 - 6'h02, {24'h0, period});
    endtask
endmodule // rcpd_host

// ### verification/ranging_command_parameter_decode_bench.sv
// Purpose: self-checking bench of the ranging command decoder
// Assumes: counts shortened to MS_CYC 20 and RANGE_CYC 10
// Notes: expectations follow the parameter byte meanings
`timescale 1ns/1ps
module ranging_command_parameter_decode_bench;
    import rcpd_pkg::*;
    localparam int MSC = 20;
    localparam int RNG = 10;
    logic core_clk, srst, psel, penable, pwrite, pready, pslverr, abortPin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic capturing, emitterHalfRate, combinedCapture, standbyReq;
    logic factoryCalUsed, algStateUsed, irq;
    logic [7:0] calBlockAddr, tag;
    int err_total, checks_done, len;
    rcpd_host host (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    rcpd_top #(.MS_CYC(MSC), .RANGE_CYC(RNG)) uut (.core_clk(core_clk),
        .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .abortPin(abortPin), .capturing(capturing),
        .emitterHalfRate(emitterHalfRate), .combinedCapture(combinedCapture),
        .standbyReq(standbyReq), .factoryCalUsed(factoryCalUsed),
        .algStateUsed(algStateUsed), .calBlockAddr(calBlockAddr), .irq(irq));
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task wait_cap(input logic v);
        int k;
        k = 0;
        while (capturing !== v && k < 100)
        begin
            cyc(1);
            k++;
        end
    endtask
    // len counts the cycles in which capturing was high
    task run(input logic [7:0] cmd, input logic [7:0] mask,
        input logic [7:0] alg, input logic [7:0] period);
        host.load(mask, alg, period);
        host.xfer(1'b1, IDX_CMD, {24'h0, cmd});
        wait_cap(1'b1);
        len = 0;
        while (capturing === 1'b1 && len < 100)
        begin
            cyc(1);
            len++;
        end
    endtask
    task t_reset;
        host.xfer(1'b0, IDX_CMD, 32'h0);
        chk(host.rdata, {24'h0, CMD_NONE});
        chk({capturing, irq, standbyReq, calBlockAddr}, 32'h0);
        $display("reset test done");
    endtask
    task t_cal;
        host.xfer(1'b1, IDX_IRQ_EN, 32'h1);
        host.xfer(1'b0, IDX_TAG, 32'h0);
        tag = host.rdata[7:0];
        run(CMD_MEAS_CAL, 8'h02, 8'hA0, 8'h00);
        chk(len, RNG);
        chk({factoryCalUsed, algStateUsed}, 2'b11);
        chk(calBlockAddr, CAL_BLOCK_ADDR);
        chk({emitterHalfRate, combinedCapture}, 2'b01);
        cyc(2);
        chk(irq, 1'b1);
        host.xfer(1'b0, IDX_TAG, 32'h0);
        chk(host.rdata[7:0], tag + 8'h01);
        host.xfer(1'b0, IDX_CMD, 32'h0);
        chk(host.rdata, 32'h0);
        host.xfer(1'b1, IDX_IRQ_CLR, 32'h3);
        cyc(2);
        chk(irq, 1'b0);
        $display("calibrated measurement test done");
    endtask
    task t_cmd2;
        run(CMD_MEAS, 8'h03, 8'h04, 8'h00);
        chk(len, 2 * RNG);
        chk(emitterHalfRate, 1'b1);
        chk({factoryCalUsed, algStateUsed, calBlockAddr}, 32'h0);
        cyc(3 * MSC);
        chk(capturing, 1'b0);
        $display("plain measurement test done");
    endtask
    // half rate keeps the capture long enough to see the deferred report still pending
    task t_abort;
        host.xfer(1'b1, IDX_IRQ_EN, 32'h2);
        for (int i = 0; i < 2; i++)
        begin
            host.load(8'h00, i ? 8'h14 : 8'h04, 8'h00);
            host.xfer(1'b1, IDX_CMD, {24'h0, CMD_MEAS_CAL});
            cyc(4);
            abortPin <= 1'b1;
            cyc(8);
            abortPin <= 1'b0;
            chk({capturing | i[0], irq}, {1'b1, i[0]});
            wait_cap(1'b0);
            cyc(3);
            chk(irq, 1'b1);
            host.xfer(1'b0, IDX_STATUS, 32'h0);
            chk(host.rdata[STS_ABORT], 1'b1);
            host.xfer(1'b1, IDX_IRQ_CLR, 32'h3);
        end
        $display("abort report test done");
    endtask
    task t_repeat;
        host.xfer(1'b1, IDX_IRQ_EN, 32'h0);
        for (int i = 0; i < 2; i++)
        begin
            run(CMD_MEAS_CAL, 8'h00, i ? 8'h80 : 8'h00, 8'h01);
            cyc(2);
            chk(standbyReq, !i[0]);
            wait_cap(1'b1);
            chk(capturing, 1'b1);
        end
        host.xfer(1'b1, IDX_CMD, {24'h0, CMD_NONE});
        wait_cap(1'b0);
        cyc(2 * MSC);
        chk(capturing, 1'b0);
        $display("repetition test done");
    endtask
    task t_apb;
        host.xfer(1'b0, 6'h3F, 32'h0);
        chk({host.rerr, host.rdata[30:0]}, 32'h8000_0000);
        host.xfer(1'b0, IDX_DATA7 + 6'h01, 32'h0);
        chk({host.rerr, host.rdata[30:0]}, 32'h0000_0083);
        $display("bus test done");
    endtask
    initial
    begin
        #100000;
        err_total++;
        conclude();
    end
    initial
    begin
        srst = 1'b1;
        abortPin = 1'b0;
        err_total = 0;
        checks_done = 0;
        cyc(16);
        srst <= 1'b0;
        t_reset();
        t_cal();
        t_cmd2();
        t_abort();
        t_repeat();
        t_apb();
        conclude();
    end
endmodule // ranging_command_parameter_decode_bench
